/* File: rtl/snd_pkg.sv */
// Constants and types of the serial memory command decoder
package snd_pkg;

	// Opcodes
	localparam logic [7:0] CMD_LATCH_SET        = 8'h06;
	localparam logic [7:0] CMD_LATCH_CLEAR      = 8'h04;
	localparam logic [7:0] CMD_STATUS_READ      = 8'h05;
	localparam logic [7:0] CMD_STATUS_WRITE     = 8'h01;
	localparam logic [7:0] CMD_ARRAY_READ       = 8'h03;
	localparam logic [7:0] CMD_ARRAY_WRITE      = 8'h02;
	localparam logic [7:0] CMD_FAST_ARRAY_READ  = 8'h0B;
	localparam logic [7:0] CMD_DEEP_POWER_DOWN  = 8'hBA;
	localparam logic [7:0] CMD_HIBERNATE        = 8'hB9;
	localparam logic [7:0] CMD_ID_READ          = 8'h9F;
	localparam logic [7:0] CMD_UNIQUE_ID_READ   = 8'h4C;
	localparam logic [7:0] CMD_SN_WRITE         = 8'hC2;
	localparam logic [7:0] CMD_SN_READ          = 8'hC3;
	localparam logic [7:0] CMD_SECTOR_WRITE     = 8'h42;
	localparam logic [7:0] CMD_SECTOR_READ      = 8'h4B;
	localparam logic [7:0] CMD_FAST_SECTOR_READ = 8'h49;

	// Bit counts: last index of each input phase, full length of the ID, unique ID and serial number outputs
	localparam logic [5:0] BITS_BYTE_LAST = 6'h07;
	localparam logic [5:0] BITS_ADDR_LAST = 6'h17;
	localparam logic [5:0] BITS_SN_LAST   = 6'h3F;
	localparam logic [6:0] ID_OUT_LEN     = 7'h20;
	localparam logic [6:0] LONG_OUT_LEN   = 7'h40;

	// Address ranges
	localparam logic [18:0] ARRAY_ADDR_MAX = 19'h7_FFFF;
	localparam logic [7:0]  SEC_ADDR_MAX   = 8'hFF;
	localparam int          SEC_BYTES      = 256;

	// Reset values
	localparam logic [2:0] PIN_RST  = 3'h4;
	localparam logic [5:0] STAT_RST = 6'h00;

	// Recovery times and cycle counts
	localparam int          CLK_MHZ         = 250;
	localparam int          DPD_REC_US      = 10;
	localparam int          HIB_REC_US      = 450;
	localparam logic [16:0] DPD_REC_CYC     = 17'(DPD_REC_US * CLK_MHZ);
	localparam logic [16:0] HIB_REC_CYC_DEF = 17'(HIB_REC_US * CLK_MHZ);

	typedef enum logic [2:0] {
		SND_ST_OPC   = 3'b000,
		SND_ST_ADDR  = 3'b001,
		SND_ST_DUMMY = 3'b010,
		SND_ST_WDATA = 3'b011,
		SND_ST_OUT   = 3'b100,
		SND_ST_ARM   = 3'b101,
		SND_ST_SKIP  = 3'b110
	} snd_state_t;

	typedef enum logic [1:0] {
		SND_PWR_ACTIVE = 2'b00,
		SND_PWR_DPD    = 2'b01,
		SND_PWR_HIB    = 2'b10,
		SND_PWR_WAKE   = 2'b11
	} snd_pwr_t;

	typedef struct packed {
		logic [18:0] addr;
		logic [7:0]  data;
	} snd_wr_req_t;

endpackage : snd_pkg

/* File: rtl/snd_buf2.sv */
// Two-entry buffer for array write requests
`timescale 1ns/1ns
module snd_buf2 import snd_pkg::*; (
	input  wire logic  ref_clk,
	input  wire logic  sys_rst,
	input  wire logic  in_valid,
	output logic       in_ready,
	input  snd_wr_req_t in_data,
	output logic       out_valid,
	input  wire logic  out_ready,
	output snd_wr_req_t out_data
);
	logic [1:0]  cnt_ff;
	logic        wr_ptr_ff;
	logic        rd_ptr_ff;
	logic        push;
	logic        pop;
	snd_wr_req_t mem_ff [2];

	assign in_ready  = (cnt_ff != 2'h2);
	assign out_valid = (cnt_ff != 2'h0);
	assign out_data  = mem_ff[rd_ptr_ff];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_ff    <= 2'h0;
			wr_ptr_ff <= 1'b0;
			rd_ptr_ff <= 1'b0;
		end else begin
			if (push)
				wr_ptr_ff <= ~wr_ptr_ff;
			if (pop)
				rd_ptr_ff <= ~rd_ptr_ff;
			if (push && !pop)
				cnt_ff <= cnt_ff + 2'h1;
			else if (pop && !push)
				cnt_ff <= cnt_ff - 2'h1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (push)
			mem_ff[wr_ptr_ff] <= in_data;
	end
endmodule : snd_buf2

/* File: rtl/snd_top.sv */
// Command decoder and sequencer of a serial nonvolatile memory
`timescale 1ns/1ns
module snd_top import snd_pkg::*; #(
	parameter logic [16:0] HIB_REC_CYC = HIB_REC_CYC_DEF,
	parameter logic [31:0] DEV_ID      = 32'h1234_5678, // Arbitrary value
	parameter logic [63:0] UNIQ_ID     = 64'h0123_4567_89AB_CDEF // Arbitrary
) (
	input  wire logic  ref_clk,
	input  wire logic  sys_rst,
	input  wire logic  cs_n_i,
	input  wire logic  sck_i,
	input  wire logic  si_i,
	output logic       so_o,
	output logic       so_oe,
	output logic [18:0] mem_rd_addr,
	output logic       mem_rd_req,
	input  wire logic [7:0] mem_rd_data,
	output logic       mem_wr_valid,
	input  wire logic  mem_wr_ready,
	output snd_wr_req_t mem_wr,
	output logic [7:0] status_o,
	output logic [1:0] pwr_state_o,
	output logic       wr_overrun_o
);
	logic [2:0]  pin_s1_ff;
	logic [2:0]  pin_s2_ff;
	logic [1:0]  pin_d_ff;
	logic        cs_fall, cs_rise, sck_rise, sck_fall, go, rise_ev, fall_ev;
	logic        in_frame_ff;
	snd_state_t  st_ff, nxt_st, dec_st;
	snd_pwr_t    pwr_ff;
	logic [5:0]  bit_cnt_ff;
	logic        phase_last, op_done;
	logic [7:0]  cmd_ff;
	logic [63:0] sh_in_ff, nxt_in;
	logic        wel_ff;
	logic [5:0]  stat_ff;
	logic [63:0] sn_ff;
	logic        sn_lock_ff;
	logic [18:0] addr_ff;
	logic        sec_end_ff, is_sector, is_fast, is_wr, byte_src, wr_byte;
	logic        rd_req_ff, rd_wait_ff;
	logic [7:0]  rd_byte_ff, src_byte;
	logic [63:0] out_sh_ff;
	logic [6:0]  out_cnt_ff, out_len;
	logic        so_ff, so_oe_ff;
	logic [16:0] wake_cnt_ff;
	logic        push_valid, push_ready, overrun_ff;
	logic [7:0]  sector_mem [SEC_BYTES];

	// Pin synchronisers, order {cs, sck, si}
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pin_s1_ff <= PIN_RST;
			pin_s2_ff <= PIN_RST;
			pin_d_ff  <= PIN_RST[2:1];
		end else begin
			pin_s1_ff <= {cs_n_i, sck_i, si_i};
			pin_s2_ff <= pin_s1_ff;
			pin_d_ff  <= pin_s2_ff[2:1];
		end
	end

	assign cs_fall  = ~pin_s2_ff[2] & pin_d_ff[1];
	assign cs_rise  = pin_s2_ff[2] & ~pin_d_ff[1];
	assign sck_rise = pin_s2_ff[1] & ~pin_d_ff[0];
	assign sck_fall = ~pin_s2_ff[1] & pin_d_ff[0];
	assign go       = in_frame_ff & ~pin_s2_ff[2];
	assign rise_ev  = go & sck_rise;
	assign fall_ev  = go & sck_fall;
	assign nxt_in   = {sh_in_ff[62:0], pin_s2_ff[0]};
	assign op_done  = rise_ev & (st_ff == SND_ST_OPC) & phase_last;

	// Frame only opens in normal operation
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			in_frame_ff <= 1'b0;
		else if (pin_s2_ff[2])
			in_frame_ff <= 1'b0;
		else if (cs_fall && pwr_ff == SND_PWR_ACTIVE)
			in_frame_ff <= 1'b1;
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			sh_in_ff <= 64'h0000_0000_0000_0000;
		else if (rise_ev)
			sh_in_ff <= nxt_in;
	end

	assign is_sector = (cmd_ff == CMD_SECTOR_WRITE) |
		(cmd_ff == CMD_SECTOR_READ) | (cmd_ff == CMD_FAST_SECTOR_READ);
	assign is_fast   = (cmd_ff == CMD_FAST_ARRAY_READ) |
		(cmd_ff == CMD_FAST_SECTOR_READ);
	assign is_wr     = (cmd_ff == CMD_ARRAY_WRITE) |
		(cmd_ff == CMD_SECTOR_WRITE);
	assign byte_src  = (cmd_ff != CMD_ID_READ) &
		(cmd_ff != CMD_UNIQUE_ID_READ) & (cmd_ff != CMD_SN_READ);

	always_comb begin
		phase_last = 1'b0;
		unique case (st_ff)
			SND_ST_OPC, SND_ST_DUMMY: phase_last = (bit_cnt_ff == BITS_BYTE_LAST);
			SND_ST_ADDR: phase_last = (bit_cnt_ff == BITS_ADDR_LAST);
			SND_ST_WDATA: phase_last = (cmd_ff == CMD_SN_WRITE) ?
				(bit_cnt_ff == BITS_SN_LAST) :
				(bit_cnt_ff[2:0] == BITS_BYTE_LAST[2:0]);
			default: phase_last = 1'b0;
		endcase
	end

	// Opcode decode
	always_comb begin
		dec_st = SND_ST_SKIP;
		case (nxt_in[7:0])
			CMD_STATUS_READ, CMD_ID_READ, CMD_UNIQUE_ID_READ, CMD_SN_READ:
				dec_st = SND_ST_OUT;
			CMD_ARRAY_READ, CMD_FAST_ARRAY_READ, CMD_SECTOR_READ,
			CMD_FAST_SECTOR_READ: dec_st = SND_ST_ADDR;
			CMD_ARRAY_WRITE, CMD_SECTOR_WRITE:
				dec_st = wel_ff ? SND_ST_ADDR : SND_ST_SKIP;
			CMD_STATUS_WRITE, CMD_SN_WRITE:
				dec_st = wel_ff ? SND_ST_WDATA : SND_ST_SKIP;
			CMD_DEEP_POWER_DOWN, CMD_HIBERNATE: dec_st = SND_ST_ARM;
			default: dec_st = SND_ST_SKIP;
		endcase
	end

	always_comb begin
		nxt_st = st_ff;
		unique case (st_ff)
			SND_ST_OPC: if (phase_last) begin
				nxt_st = dec_st;
			end
			SND_ST_ADDR: if (phase_last) begin
				nxt_st = is_fast ? SND_ST_DUMMY :
					(is_wr ? SND_ST_WDATA : SND_ST_OUT);
			end
			SND_ST_DUMMY: if (phase_last) begin
				nxt_st = SND_ST_OUT;
			end
			SND_ST_WDATA: if (phase_last && !is_wr) begin
				nxt_st = SND_ST_SKIP;
			end
			SND_ST_ARM: nxt_st = SND_ST_SKIP;
			SND_ST_OUT, SND_ST_SKIP: nxt_st = st_ff;
			default: nxt_st = SND_ST_SKIP;
		endcase
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_ff      <= SND_ST_OPC;
			bit_cnt_ff <= 6'h00;
			cmd_ff     <= 8'h00;
		end else if (cs_fall) begin
			st_ff      <= SND_ST_OPC;
			bit_cnt_ff <= 6'h00;
		end else if (rise_ev) begin
			st_ff      <= nxt_st;
			bit_cnt_ff <= (nxt_st != st_ff) ? 6'h00 : bit_cnt_ff + 6'h01;
			if (st_ff == SND_ST_OPC && phase_last)
				cmd_ff <= nxt_in[7:0];
		end
	end

	// Write enable latch
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			wel_ff <= 1'b0;
		else if (cs_fall && (pwr_ff == SND_PWR_DPD || pwr_ff == SND_PWR_HIB))
			wel_ff <= 1'b0;
		else if (op_done && nxt_in[7:0] == CMD_LATCH_SET)
			wel_ff <= 1'b1;
		else if (op_done && nxt_in[7:0] == CMD_LATCH_CLEAR)
			wel_ff <= 1'b0;
	end

	// Status and serial number
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			stat_ff    <= STAT_RST;
			sn_ff      <= 64'h0000_0000_0000_0000;
			sn_lock_ff <= 1'b0;
		end else if (rise_ev && st_ff == SND_ST_WDATA && phase_last) begin
			if (cmd_ff == CMD_STATUS_WRITE)
				stat_ff <= nxt_in[7:2];
			if (cmd_ff == CMD_SN_WRITE && !sn_lock_ff) begin
				sn_ff      <= nxt_in;
				sn_lock_ff <= 1'b1;
			end
		end
	end

	assign status_o = {stat_ff, wel_ff, 1'b0};
	assign wr_byte  = rise_ev & (st_ff == SND_ST_WDATA) & is_wr &
		(bit_cnt_ff[2:0] == BITS_BYTE_LAST[2:0]);

	// Address, prefetch and sector end
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			addr_ff    <= 19'h0_0000;
			sec_end_ff <= 1'b0;
		end else if (cs_fall) begin
			sec_end_ff <= 1'b0;
		end else if (rise_ev && st_ff == SND_ST_ADDR && phase_last) begin
			addr_ff <= is_sector ? {11'h000, nxt_in[7:0]} : nxt_in[18:0];
		end else if (wr_byte || rd_wait_ff) begin
			if (!is_sector)
				addr_ff <= addr_ff + 19'h0_0001;
			else if (addr_ff[7:0] == SEC_ADDR_MAX)
				sec_end_ff <= 1'b1;
			else
				addr_ff <= addr_ff + 19'h0_0001;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rd_req_ff  <= 1'b0;
			rd_wait_ff <= 1'b0;
			rd_byte_ff <= 8'h00;
		end else begin
			rd_req_ff  <= (rise_ev && phase_last && !is_wr &&
				((st_ff == SND_ST_ADDR && !is_fast) || st_ff == SND_ST_DUMMY)) ||
				(fall_ev && st_ff == SND_ST_OUT && byte_src &&
				cmd_ff != CMD_STATUS_READ && out_cnt_ff[2:0] == 3'h0);
			rd_wait_ff <= rd_req_ff;
			if (rd_wait_ff)
				rd_byte_ff <= !is_sector ? mem_rd_data :
					(sec_end_ff ? 8'h00 : sector_mem[addr_ff[7:0]]);
		end
	end

	assign mem_rd_addr = addr_ff;
	assign mem_rd_req  = rd_req_ff;

	always_ff @(posedge ref_clk) begin
		if (wr_byte && cmd_ff == CMD_SECTOR_WRITE && !sec_end_ff)
			sector_mem[addr_ff[7:0]] <= nxt_in[7:0];
	end

	// Output shifter, changes on SCK falling edges
	assign src_byte = (cmd_ff == CMD_STATUS_READ) ? status_o : rd_byte_ff;
	assign out_len  = (cmd_ff == CMD_ID_READ) ? ID_OUT_LEN : LONG_OUT_LEN;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			out_sh_ff  <= 64'h0000_0000_0000_0000;
			out_cnt_ff <= 7'h00;
			so_ff      <= 1'b0;
		end else if (cs_fall) begin
			out_cnt_ff <= 7'h00;
		end else if (op_done) begin
			unique case (nxt_in[7:0])
				CMD_ID_READ: out_sh_ff <= {DEV_ID, 32'h0000_0000};
				CMD_UNIQUE_ID_READ: out_sh_ff <= UNIQ_ID;
				CMD_SN_READ: out_sh_ff <= sn_ff;
				default: out_sh_ff <= out_sh_ff;
			endcase
		end else if (fall_ev && st_ff == SND_ST_OUT) begin
			if (byte_src) begin
				out_cnt_ff <= out_cnt_ff + 7'h01;
				if (out_cnt_ff[2:0] == 3'h0) begin
					so_ff     <= src_byte[7];
					out_sh_ff <= {src_byte[6:0], 57'h0};
				end else begin
					so_ff     <= out_sh_ff[63];
					out_sh_ff <= {out_sh_ff[62:0], 1'b0};
				end
			end else if (out_cnt_ff < out_len) begin
				out_cnt_ff <= out_cnt_ff + 7'h01;
				so_ff      <= out_sh_ff[63];
				out_sh_ff  <= {out_sh_ff[62:0], 1'b0};
			end
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			so_oe_ff <= 1'b0;
		else if (!go)
			so_oe_ff <= 1'b0;
		else if (fall_ev && st_ff == SND_ST_OUT)
			so_oe_ff <= 1'b1;
	end

	assign so_o  = so_ff;
	assign so_oe = so_oe_ff;

	// Low-power modes
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pwr_ff      <= SND_PWR_ACTIVE;
			wake_cnt_ff <= 17'h0_0000;
		end else begin
			unique case (pwr_ff)
				SND_PWR_ACTIVE: if (cs_rise && in_frame_ff && st_ff == SND_ST_ARM) begin
					pwr_ff <= (cmd_ff == CMD_DEEP_POWER_DOWN) ?
						SND_PWR_DPD : SND_PWR_HIB;
				end
				SND_PWR_DPD, SND_PWR_HIB: if (cs_fall) begin
					pwr_ff      <= SND_PWR_WAKE;
					wake_cnt_ff <= (pwr_ff == SND_PWR_DPD) ?
						DPD_REC_CYC - 17'h0_0001 :
						HIB_REC_CYC - 17'h0_0001;
				end
				SND_PWR_WAKE: if (wake_cnt_ff == 17'h0_0000) begin
					pwr_ff <= SND_PWR_ACTIVE;
				end else begin
					wake_cnt_ff <= wake_cnt_ff - 17'h0_0001;
				end
			endcase
		end
	end

	assign pwr_state_o = pwr_ff;

	// Array write path
	assign push_valid = wr_byte & (cmd_ff == CMD_ARRAY_WRITE);

	snd_buf2 u_wr_buf (
		.ref_clk   (ref_clk),
		.sys_rst   (sys_rst),
		.in_valid  (push_valid),
		.in_ready  (push_ready),
		.in_data   ({addr_ff, nxt_in[7:0]}),
		.out_valid (mem_wr_valid),
		.out_ready (mem_wr_ready),
		.out_data  (mem_wr)
	);

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			overrun_ff <= 1'b0;
		else if (push_valid && !push_ready)
			overrun_ff <= 1'b1;
	end

	assign wr_overrun_o = overrun_ff;

	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	property p_oe_idle;
		pin_s2_ff[2] |=> !so_oe_ff;
	endproperty
	a_oe_idle: assert property (p_oe_idle) else $error("SO driven while deselected");

	property p_lowpwr_quiet;
		(pwr_ff != SND_PWR_ACTIVE) |-> !so_oe_ff && !in_frame_ff;
	endproperty
	a_lowpwr_quiet: assert property (p_lowpwr_quiet) else $error("Active in low power");

	property p_latch_clear;
		op_done && nxt_in[7:0] == CMD_LATCH_CLEAR |=> !wel_ff;
	endproperty
	a_latch_clear: assert property (p_latch_clear) else $error("Latch not cleared");

	property p_latch_set;
		op_done && nxt_in[7:0] == CMD_LATCH_SET |=> wel_ff;
	endproperty
	a_latch_set: assert property (p_latch_set) else $error("Latch not set");

	property p_wr_needs_wel;
		push_valid |-> wel_ff && st_ff == SND_ST_WDATA;
	endproperty
	a_wr_needs_wel: assert property (p_wr_needs_wel) else $error("Write without latch");

	property p_arm_cancel;
		st_ff == SND_ST_ARM && rise_ev |=> st_ff == SND_ST_SKIP ##1 pwr_ff == SND_PWR_ACTIVE;
	endproperty
	a_arm_cancel: assert property (p_arm_cancel) else $error("Power down not cancelled");

	property p_dpd_wake;
		pwr_ff == SND_PWR_DPD && cs_fall |=>
			pwr_ff == SND_PWR_WAKE && wake_cnt_ff == DPD_REC_CYC - 17'h0_0001 && !wel_ff;
	endproperty
	a_dpd_wake: assert property (p_dpd_wake) else $error("Bad wake start");

	property p_wake_done;
		pwr_ff == SND_PWR_WAKE && wake_cnt_ff == 17'h0_0000 |=> pwr_ff == SND_PWR_ACTIVE;
	endproperty
	a_wake_done: assert property (p_wake_done) else $error("Wake overrun");

	property p_sn_once;
		sn_lock_ff |=> $stable(sn_ff) && sn_lock_ff;
	endproperty
	a_sn_once: assert property (p_sn_once) else $error("Serial number rewritten");

	property p_array_wrap;
		push_valid && addr_ff == ARRAY_ADDR_MAX |=> addr_ff == 19'h0_0000;
	endproperty
	a_array_wrap: assert property (p_array_wrap) else $error("No address wrap");

	property p_sec_nowrap;
		sec_end_ff && !cs_fall |=> sec_end_ff && $stable(addr_ff);
	endproperty
	a_sec_nowrap: assert property (p_sec_nowrap) else $error("Sector address moved");

	property p_id_hold;
		fall_ev && st_ff == SND_ST_OUT && cmd_ff == CMD_ID_READ &&
			out_cnt_ff == ID_OUT_LEN |=> $stable(so_ff);
	endproperty
	a_id_hold: assert property (p_id_hold) else $error("Id last bit not held");

	c_status_rd: cover property (so_oe_ff && cmd_ff == CMD_STATUS_READ);
	c_dpd_enter: cover property (pwr_ff == SND_PWR_DPD);
	c_sec_end: cover property (sec_end_ff && cmd_ff == CMD_SECTOR_WRITE);
	c_arr_push: cover property (push_valid);
endmodule : snd_top

/* File: bench/snd_host.sv */
// SPI host model that frames commands for the decoder
`timescale 1ns/1ns
module snd_host (
	input  wire logic ref_clk,
	output logic      cs_n,
	output logic      sck,
	output logic      si,
	input  wire logic so_w
);
	task automatic half();
		repeat (10) @(negedge ref_clk);
	endtask : half

	// One frame of n bits, SO taken at each SCK rise
	task automatic frame(input logic [127:0] tx, input int n,
		output logic [127:0] rx);
		rx = '0;
		cs_n = 1'b0;
		half();
		for (int i = n - 1; i >= 0; i--) begin
			si = tx[i];
			half();
			sck = 1'b1;
			rx = {rx[126:0], so_w};
			half();
			sck = 1'b0;
		end
		si = ~si;
		half();
		cs_n = 1'b1;
		repeat (3) half();
	endtask : frame

	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		si = 1'b0;
	end
endmodule : snd_host

/* File: bench/spi_nvram_command_decoder_tb.sv */
// Self-checking bench of the serial memory command decoder
`timescale 1ns/1ns
module spi_nvram_command_decoder_tb import snd_pkg::*;;
	localparam logic [31:0] ID_EXP  = 32'h5A5A_0F0F; // Arbitrary value
	localparam logic [63:0] UID_EXP = 64'h1111_2222_3333_4444; // Arbitrary
	logic        ref_clk, sys_rst, cs_n, sck, si, so_o, so_oe;
	logic        mem_rd_req, mem_wr_valid, mem_wr_ready, wr_overrun_o;
	logic        stall, oe_seen;
	logic [18:0] mem_rd_addr;
	logic [7:0]  mem_rd_data, status_o;
	logic [1:0]  pwr_state_o;
	logic [127:0] rx;
	logic [63:0] sn;
	logic [15:0] d;
	snd_wr_req_t mem_wr;
	snd_wr_req_t wq[$];
	int          miscompares = 0;
	int          check_count = 0;
	int          cyc = 0;
	int          seed = 32'h69e3;
	wire         so_w = so_oe ? so_o : ~so_o;

	snd_top #(.HIB_REC_CYC(17'd20), .DEV_ID(ID_EXP), .UNIQ_ID(UID_EXP)) uut (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .cs_n_i(cs_n), .sck_i(sck),
		.si_i(si), .so_o(so_o), .so_oe(so_oe), .mem_rd_addr(mem_rd_addr),
		.mem_rd_req(mem_rd_req), .mem_rd_data(mem_rd_data),
		.mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready),
		.mem_wr(mem_wr), .status_o(status_o), .pwr_state_o(pwr_state_o),
		.wr_overrun_o(wr_overrun_o));
	snd_host host (.ref_clk(ref_clk), .cs_n(cs_n), .sck(sck), .si(si),
		.so_w(so_w));

	function automatic logic [7:0] pat(input logic [18:0] a);
		return a[7:0] ^ a[18:11];
	endfunction : pat

	task automatic chk(input string nm, input logic [63:0] e,
		input logic [63:0] g);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask : chk

	task automatic conclude();
		if (miscompares == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : conclude

	task automatic op(input logic [7:0] c);
		host.frame(128'(c), 8, rx);
	endtask : op

	// Status read of two bytes plus the status port
	task automatic st(input logic [7:0] e);
		host.frame({CMD_STATUS_READ, 16'($random(seed))}, 24, rx);
		chk("status", {e, e}, rx[15:0]);
		chk("status_o", e, status_o);
	endtask : st

	task automatic wake(input int lim, input int pw);
		op(CMD_LATCH_SET);
		op(pw == 1 ? CMD_DEEP_POWER_DOWN : CMD_HIBERNATE);
		chk("pwr", pw, pwr_state_o);
		oe_seen = 1'b0;
		host.frame({CMD_STATUS_READ, 16'h0}, 24, rx);
		chk("oe asleep", 0, oe_seen);
		for (int i = 0; i < lim && pwr_state_o !== 2'd0; i++)
			@(negedge ref_clk);
		chk("awake", 0, pwr_state_o);
		st(8'hFC);
	endtask : wake

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	always @(negedge ref_clk) begin
		if (mem_rd_req === 1'b1)
			mem_rd_data <= pat(mem_rd_addr);
		mem_wr_ready <= !stall && $random(seed);
	end

	always @(posedge ref_clk) begin
		cyc++;
		if (so_oe === 1'b1)
			oe_seen = 1'b1;
		if (mem_wr_valid === 1'b1 && mem_wr_ready === 1'b1) begin
			if (wq.size() == 0)
				chk("mem_wr extra", 0, 1);
			else
				chk("mem_wr", wq.pop_front(), mem_wr);
		end
		if (cyc == 40000) begin
			miscompares++;
			conclude();
		end
	end

	initial begin
		sys_rst = 1'b1;
		stall = 1'b0;
		oe_seen = 1'b0;
		mem_rd_data = 8'h00;
		mem_wr_ready = 1'b0;
		repeat (8) @(negedge ref_clk);
		sys_rst = 1'b0;
		repeat (4) @(negedge ref_clk);
		st(8'h00);
		op(CMD_LATCH_SET);
		st(8'h02);
		host.frame({CMD_STATUS_WRITE, 8'hFF}, 16, rx);
		st(8'hFE);
		op(CMD_LATCH_CLEAR);
		host.frame({CMD_STATUS_WRITE, 8'h00}, 16, rx);
		st(8'hFC);
		host.frame(128'h03, 7, rx);
		chk("so_oe idle", 0, so_oe);
		st(8'hFC);
		op(CMD_LATCH_SET);
		d = 16'($random(seed));
		stall = 1'b1;
		wq.push_back({19'h7_FFFF, d[15:8]});
		wq.push_back({19'h0_0000, d[7:0]});
		host.frame({CMD_ARRAY_WRITE, 24'hF7_FFFF, d}, 48, rx);
		chk("held", 1, mem_wr_valid);
		stall = 1'b0;
		for (int i = 0; i < 60 && wq.size() > 0; i++)
			@(negedge ref_clk);
		chk("drained", 0, wq.size());
		chk("overrun", 0, wr_overrun_o);
		st(8'hFE);
		host.frame({CMD_ARRAY_READ, 24'hE7_FFFE, 24'($random(seed))}, 56, rx);
		chk("read", {pat(19'h7_FFFE), pat(19'h7_FFFF), pat(19'h0)},
			rx[23:0]);
		host.frame({CMD_FAST_ARRAY_READ, 24'h07_FFFF, 32'($random(seed))},
			64, rx);
		chk("fast", {pat(19'h7_FFFF), pat(19'h0), pat(19'h1)},
			rx[23:0]);
		host.frame({CMD_ID_READ, 40'($random(seed))}, 48, rx);
		chk("id", {ID_EXP, {8{ID_EXP[0]}}}, rx[39:0]);
		host.frame({CMD_UNIQUE_ID_READ, 64'($random(seed))}, 72, rx);
		chk("uid", UID_EXP, rx[63:0]);
		host.frame({CMD_SN_READ, 64'h0}, 72, rx);
		chk("sn blank", 0, rx[63:0]);
		sn = {32'($random(seed)), 32'($random(seed))};
		host.frame({CMD_SN_WRITE, sn}, 72, rx);
		host.frame({CMD_SN_WRITE, ~sn}, 72, rx);
		host.frame({CMD_SN_READ, 64'h0}, 72, rx);
		chk("sn", sn, rx[63:0]);
		host.frame({CMD_SECTOR_WRITE, 24'h12_34FE, d, 16'hFFFF}, 64, rx);
		host.frame({CMD_SECTOR_READ, 24'hAB_CDFE, 24'h0}, 56, rx);
		chk("sector", {d, 8'h00}, rx[23:0]);
		host.frame({CMD_FAST_SECTOR_READ, 24'h00_00FF, 16'h0}, 48, rx);
		chk("fast sector", d[7:0], rx[7:0]);
		host.frame({CMD_DEEP_POWER_DOWN, 1'b0}, 9, rx);
		chk("cancel", 0, pwr_state_o);
		host.frame({CMD_HIBERNATE, 1'b0}, 9, rx);
		chk("cancel hib", 0, pwr_state_o);
		wake(2510, 1);
		wake(30, 2);
		oe_seen = 1'b0;
		host.frame({8'hCE, 16'h0}, 24, rx);
		chk("rfu oe", 0, oe_seen);
		host.frame({CMD_ARRAY_WRITE, 24'h00_0020, d[7:0]}, 40, rx);
		chk("locked wr", 0, mem_wr_valid);
		op(CMD_LATCH_SET);
		stall = 1'b1;
		wq.push_back({19'h0_0010, d[15:8]});
		wq.push_back({19'h0_0011, d[7:0]});
		host.frame({CMD_ARRAY_WRITE, 24'h00_0010, d, 8'h5A}, 56, rx);
		chk("overrun set", 1, wr_overrun_o);
		stall = 1'b0;
		for (int i = 0; i < 60 && wq.size() > 0; i++)
			@(negedge ref_clk);
		chk("drained 2", 0, wq.size());
		sys_rst = 1'b1;
		repeat (2) @(negedge ref_clk);
		sys_rst = 1'b0;
		chk("rst overrun", 0, wr_overrun_o);
		chk("rst valid", 0, mem_wr_valid);
		chk("rst oe", 0, so_oe);
		chk("rst pwr", 0, pwr_state_o);
		repeat (4) @(negedge ref_clk);
		st(8'h00);
		conclude();
	end
endmodule : spi_nvram_command_decoder_tb
